// ===== rtl/viau_pkg.sv
package viau_pkg;

  // Register byte offsets
  localparam logic [7:0] VIAU_OFF_CFG  = 8'h00;
  localparam logic [7:0] VIAU_OFF_GSUM = 8'h04;
  localparam logic [7:0] VIAU_OFF_STA  = 8'h08;
  localparam logic [7:0] VIAU_OFF_STB  = 8'h0c;
  localparam logic [7:0] VIAU_OFF_STP  = 8'h10;
  localparam logic [7:0] VIAU_OFF_MSKA = 8'h14;
  localparam logic [7:0] VIAU_OFF_MSKB = 8'h18;
  localparam logic [7:0] VIAU_OFF_MSKP = 8'h1c;

  // irq_port_config field positions
  localparam int VIAU_CFG_DAISY_BIT = 0;
  localparam int VIAU_CFG_ADDR_LSB  = 1;
  localparam int VIAU_CFG_SHOW_BIT  = 3;
  localparam logic [3:0] VIAU_CFG_RESET = 4'h0;
  localparam logic [7:0] VIAU_MASK_RESET = 8'h00;
  localparam logic [7:0] VIAU_STAT_RESET = 8'h00;

  // Urgent status bits per channel: receive, receive end, transmit
  localparam int VIAU_URG_RX_BIT  = 0;
  localparam int VIAU_URG_RXE_BIT = 1;
  localparam int VIAU_URG_TX_BIT  = 2;
  localparam logic [7:0] VIAU_URG_MASK = 8'h07;

  // Vector code per group, index 0 is group 1
  localparam logic [7:0] VIAU_VEC_TBL [8] = '{
    8'h01, 8'h02, 8'h04, 8'h11, 8'h12, 8'h14, 8'h08, 8'h18
  };

  localparam logic [1:0] VIAU_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VIAU_RESP_SLVERR = 2'h2;

  // Event sources: one byte per status register
  typedef struct packed {
    logic [7:0] port;
    logic [7:0] chan_b;
    logic [7:0] chan_a;
  } viau_src_type;

  typedef enum logic [2:0] {
    ACK_IDLE,
    ACK_P1_LOW,
    ACK_P1_DONE,
    ACK_VEC,
    ACK_IGNORE
  } viau_ack_state_type;

endpackage

// ===== rtl/viau_top.sv
// Functional notes
// (RULE1) Request then acknowledge strobe; two pulses in strobe mode, one in direction mode.
// (RULE2) Acknowledge behaviour follows cascading mode and the two chain pin levels.
// (RULE3) Slave mode accepts acknowledge only when chain pin address matches programmed address.
// (RULE4) Single device: board ties chain pins to the programmed slave address.
// (RULE5) Daisy mode accepts acknowledge only while chain enable input is active.
// (RULE6) Daisy chain output follows input, forced inactive while own request is active.
// (RULE7) Daisy mode never newly raises request during an acknowledge cycle.
// (RULE8) Accepted acknowledge drives eight-bit vector on the lowest data byte.
// (RULE9) Eight fixed-priority groups; vector names highest active group, group one first.
// (RULE10) Groups one to six are single urgent bits cleared when acknowledge ends.
// (RULE11) Groups seven and eight need software to poll summary and status registers.
// (RULE12) Port source alone is reported as group seven.
// (RULE13) Request drops once every pending indication is cleared, daisy mode excepted.
// (RULE14) One source per vector, chosen among unmasked active sources only.
// (RULE15) Show option off: masked events held inside, hidden until mask cleared.
// (RULE16) Show option on: masked events visible, yet no request, vector or summary.
// (RULE17) Show option on: status read clears all active bits, masked or not.
// (RULE18) Polling software reads each status register; summary shows only unmasked requests.
// (RULE19) Each status bit has its own mask bit in the matching mask register.
// (RULE20) Status read clears its bits and summary bit; request drops when summary clear.
// (RULE21) Vector group encoding is a fixed constant table.
`timescale 1ns/1ps
module viau_top
  import viau_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire viau_src_type src_event,
  input  wire logic         irq_ack_strobe_n,
  input  wire logic         bus_mode_two_pulse,
  input  wire logic         chain_enable_out_or_addr_lo_i,
  output logic              chain_enable_out_or_addr_lo_o,
  output logic              chain_enable_out_or_addr_lo_oe,
  input  wire logic         chain_enable_in_or_addr_hi,
  output logic [7:0]        vec_data_o,
  output logic              vec_data_oe,
  output logic              irq_req
);
  // Pin synchronisers: three stages, change taken when stages two and three agree
  logic [3:0] pin_raw;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_q;
  assign pin_raw = {bus_mode_two_pulse, chain_enable_out_or_addr_lo_i,
                    chain_enable_in_or_addr_hi, irq_ack_strobe_n};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_s1_q[gi] <= 1'b1;
          pin_s2_q[gi] <= 1'b1;
          pin_s3_q[gi] <= 1'b1;
          pin_q[gi]    <= 1'b1;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate
  logic strobe_low;
  logic strobe_low_prev_q;
  logic strobe_fall;
  logic strobe_rise;
  logic chain_in;
  logic addr_lo_in;
  logic two_pulse;
  assign strobe_low  = !pin_q[0];
  assign chain_in    = pin_q[1];
  assign addr_lo_in  = pin_q[2];
  assign two_pulse   = pin_q[3];
  assign strobe_fall = strobe_low && !strobe_low_prev_q;
  assign strobe_rise = !strobe_low && strobe_low_prev_q;
  logic [3:0]      cfg_q;
  logic [2:0][7:0] mask_q;
  logic [2:0][7:0] stat_q;
  logic            daisy;
  logic [1:0]      slave_addr;
  logic            show_masked;
  assign daisy       = cfg_q[VIAU_CFG_DAISY_BIT];
  assign slave_addr  = cfg_q[VIAU_CFG_ADDR_LSB +: 2];
  assign show_masked = cfg_q[VIAU_CFG_SHOW_BIT];
  // Unmasked view drives summary, request and vector
  logic [2:0][7:0] live;
  logic [2:0][7:0] shown;
  logic [2:0]      gsum;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_view
      assign live[gi]  = stat_q[gi] & ~mask_q[gi]; // RULE14 RULE19
      assign shown[gi] = show_masked ? stat_q[gi] : live[gi]; // RULE15 RULE16
      assign gsum[gi]  = |live[gi]; // RULE16 RULE18
    end
  endgenerate
  logic [7:0] grp_act;
  logic [2:0] grp_sel;
  logic       any_pending;
  assign grp_act[0] = live[0][VIAU_URG_RX_BIT];
  assign grp_act[1] = live[0][VIAU_URG_RXE_BIT];
  assign grp_act[2] = live[0][VIAU_URG_TX_BIT];
  assign grp_act[3] = live[1][VIAU_URG_RX_BIT];
  assign grp_act[4] = live[1][VIAU_URG_RXE_BIT];
  assign grp_act[5] = live[1][VIAU_URG_TX_BIT];
  assign grp_act[6] = |(live[0] & ~VIAU_URG_MASK) || (|live[2]); // RULE12
  assign grp_act[7] = |(live[1] & ~VIAU_URG_MASK);
  assign any_pending = |gsum;
  function automatic logic [2:0] prio_first(input logic [7:0] act);
    logic [2:0] idx;
    idx = 3'h7;
    for (int k = 7; k >= 0; k--) begin
      if (act[k]) begin
        idx = 3'(k);
      end
    end
    return idx;
  endfunction
  assign grp_sel = prio_first(grp_act); // RULE9
  logic addr_match;
  logic ack_ok;
  assign addr_match = ({chain_in, addr_lo_in} == slave_addr); // RULE3
  assign ack_ok     = daisy ? chain_in : addr_match; // RULE2 RULE5
  viau_ack_state_type ack_state_q;
  viau_ack_state_type ack_state_d;
  logic [2:0]         ack_grp_q;
  logic               ack_busy;
  logic               ack_done;
  always_comb begin
    ack_state_d = ack_state_q;
    case (ack_state_q)
      ACK_IDLE: begin
        if (strobe_fall) begin
          if (!ack_ok) begin
            ack_state_d = ACK_IGNORE;
          end else if (two_pulse) begin
            ack_state_d = ACK_P1_LOW; // RULE1
          end else begin
            ack_state_d = ACK_VEC; // RULE1
          end
        end
      end
      ACK_P1_LOW: begin
        if (strobe_rise) begin
          ack_state_d = ACK_P1_DONE;
        end
      end
      ACK_P1_DONE: begin
        if (strobe_fall) begin
          ack_state_d = ACK_VEC;
        end
      end
      ACK_VEC: begin
        if (strobe_rise) begin
          ack_state_d = ACK_IDLE;
        end
      end
      ACK_IGNORE: begin
        if (strobe_rise) begin
          ack_state_d = ACK_IDLE;
        end
      end
      default: begin
        ack_state_d = ACK_IDLE;
      end
    endcase
  end
  assign ack_busy = (ack_state_q != ACK_IDLE) || strobe_low;
  assign ack_done = (ack_state_q == ACK_VEC) && strobe_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_state_q       <= ACK_IDLE;
      ack_grp_q         <= 3'h0;
      strobe_low_prev_q <= 1'b0;
      vec_data_o        <= 8'h00;
      vec_data_oe       <= 1'b0;
    end else begin
      ack_state_q       <= ack_state_d;
      strobe_low_prev_q <= strobe_low;
      if (ack_state_d == ACK_VEC && ack_state_q != ACK_VEC) begin
        ack_grp_q  <= grp_sel;
        vec_data_o <= VIAU_VEC_TBL[grp_sel]; // RULE8 RULE21
      end
      vec_data_oe <= (ack_state_d == ACK_VEC); // RULE8
    end
  end
  // Request and daisy chain output
  logic irq_d;
  assign irq_d = daisy ? (any_pending && chain_in && (irq_req || !ack_busy)) // RULE7
                       : any_pending; // RULE13 RULE20
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req                        <= 1'b0;
      chain_enable_out_or_addr_lo_o  <= 1'b0;
      chain_enable_out_or_addr_lo_oe <= 1'b0;
    end else begin
      irq_req                        <= irq_d;
      chain_enable_out_or_addr_lo_o  <= chain_in && !irq_d; // RULE6
      chain_enable_out_or_addr_lo_oe <= daisy; // RULE6
    end
  end
  // AXI4-Lite write channel
  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic       w_lane0_q;
  logic       wr_fire;
  logic [3:0] wr_idx;
  logic       wr_map;
  logic       wr_en;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_byte_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= VIAU_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q  <= 1'b1;
        w_byte_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? VIAU_RESP_OKAY : VIAU_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  function automatic logic [3:0] reg_dec(input logic [7:0] a);
    logic [3:0] r;
    r = 4'hf;
    case (a)
      VIAU_OFF_CFG:  r = 4'h0;
      VIAU_OFF_GSUM: r = 4'h1;
      VIAU_OFF_STA:  r = 4'h2;
      VIAU_OFF_STB:  r = 4'h3;
      VIAU_OFF_STP:  r = 4'h4;
      VIAU_OFF_MSKA: r = 4'h5;
      VIAU_OFF_MSKB: r = 4'h6;
      VIAU_OFF_MSKP: r = 4'h7;
      default:       r = 4'hf;
    endcase
    return r;
  endfunction
  assign wr_idx = reg_dec(aw_addr_q);
  assign wr_map = (wr_idx != 4'hf);
  assign wr_en  = wr_fire && w_lane0_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q  <= VIAU_CFG_RESET;
      mask_q <= {3{VIAU_MASK_RESET}};
    end else if (wr_en) begin
      if (wr_idx == 4'h0) begin
        cfg_q <= w_byte_q[3:0];
      end
      for (int k = 0; k < 3; k++) begin
        if (wr_idx == 4'(k + 5)) begin
          mask_q[k] <= w_byte_q; // RULE19
        end
      end
    end
  end
  // AXI4-Lite read channel
  logic [3:0] rd_idx;
  logic       rd_fire;
  logic [7:0] rd_byte;
  assign rd_idx  = reg_dec(s_axi_araddr);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      4'h0:    rd_byte = {4'h0, cfg_q};
      4'h1:    rd_byte = {5'h00, gsum};
      4'h2:    rd_byte = shown[0];
      4'h3:    rd_byte = shown[1];
      4'h4:    rd_byte = shown[2];
      4'h5:    rd_byte = mask_q[0];
      4'h6:    rd_byte = mask_q[1];
      4'h7:    rd_byte = mask_q[2];
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= VIAU_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= (rd_idx == 4'hf) ? VIAU_RESP_SLVERR : VIAU_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Sticky status; new events win over any clear in the same cycle
  logic [2:0][7:0] ev;
  logic [2:0][7:0] clr;
  logic [7:0]      urg_clr;
  assign ev = {src_event.port, src_event.chan_b, src_event.chan_a};
  always_comb begin
    urg_clr = 8'h00;
    if (ack_done && ack_grp_q < 3'h6) begin
      urg_clr[3'(ack_grp_q % 3'h3)] = 1'b1; // RULE10
    end
  end
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stat
      logic rd_hit;
      logic [7:0] rd_clr;
      logic [7:0] ack_clr;
      assign rd_hit  = rd_fire && (rd_idx == 4'(gi + 2));
      assign rd_clr  = rd_hit ? shown[gi] : 8'h00; // RULE17 RULE20
      assign ack_clr = (gi < 2 && (ack_grp_q / 3'h3) == 3'(gi)) ? urg_clr : 8'h00;
      assign clr[gi] = rd_clr | ack_clr;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stat_q[gi] <= VIAU_STAT_RESET;
        end else begin
          stat_q[gi] <= (stat_q[gi] & ~clr[gi]) | ev[gi]; // RULE15
        end
      end
    end
  endgenerate
endmodule

// ===== sim/viau_host.sv
`timescale 1ns/1ps
module viau_host (
  input  wire logic       aclk,
  input  wire logic [7:0] vec_data_o,
  input  wire logic       vec_data_oe,
  output logic            irq_ack_strobe_n,
  output logic [7:0]      seen,
  output logic            got
);
  initial begin
    irq_ack_strobe_n = 1'b1;
    seen = 8'h00;
    got = 1'b0;
  end
  // Each strobe level held 8 cycles, vector captured while driven
  task automatic level(input logic v);
    irq_ack_strobe_n <= v;
    repeat (8) begin
      @(posedge aclk);
      if (vec_data_oe === 1'b1) begin
        got <= 1'b1;
        seen <= vec_data_o;
      end
    end
  endtask
  task automatic ack_cycle(input logic two_pulse);
    @(posedge aclk);
    got <= 1'b0;
    if (two_pulse) begin
      level(1'b0);
      level(1'b1);
    end
    level(1'b0);
    level(1'b1);
  endtask
endmodule

// ===== sim/viau_sva.sv
`timescale 1ns/1ps
module viau_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       irq_ack_strobe_n,
  input wire logic       chain_enable_in_or_addr_hi,
  input wire logic       chain_enable_out_or_addr_lo_o,
  input wire logic       chain_enable_out_or_addr_lo_oe,
  input wire logic [7:0] vec_data_o,
  input wire logic       vec_data_oe,
  input wire logic       irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire daisy = chain_enable_out_or_addr_lo_oe;
  wire cin = chain_enable_in_or_addr_hi;
  property p_chain_low; (daisy && irq_req)[*3] |-> !chain_enable_out_or_addr_lo_o; endproperty
  a_chain_low: assert property (p_chain_low) else $error("chain out high");
  property p_chain_follow; (daisy && !cin)[*6] |-> !chain_enable_out_or_addr_lo_o; endproperty
  a_chain_follow: assert property (p_chain_follow) else $error("chain out without in");
  property p_gate; (daisy && !cin)[*6] |-> !irq_req; endproperty
  a_gate: assert property (p_gate) else $error("request without chain in");
  property p_no_new; daisy && vec_data_oe && $past(vec_data_oe) |-> !$rose(irq_req); endproperty
  a_no_new: assert property (p_no_new) else $error("request raised in ack");
  property p_code;
    vec_data_oe |-> vec_data_o inside {8'h01, 8'h02, 8'h04, 8'h11, 8'h12, 8'h14, 8'h08, 8'h18};
  endproperty
  a_code: assert property (p_code) else $error("bad vector code");
  property p_stable; vec_data_oe && $past(vec_data_oe) |-> $stable(vec_data_o); endproperty
  a_stable: assert property (p_stable) else $error("vector changed");
  property p_start; $rose(vec_data_oe) |-> !$past(irq_ack_strobe_n, 2); endproperty
  a_start: assert property (p_start) else $error("vector without strobe");
  property p_end; $rose(irq_ack_strobe_n) |-> ##[1:6] !vec_data_oe; endproperty
  a_end: assert property (p_end) else $error("vector held too long");
endmodule
bind viau_top viau_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .irq_ack_strobe_n(irq_ack_strobe_n),
  .chain_enable_in_or_addr_hi(chain_enable_in_or_addr_hi),
  .chain_enable_out_or_addr_lo_o(chain_enable_out_or_addr_lo_o),
  .chain_enable_out_or_addr_lo_oe(chain_enable_out_or_addr_lo_oe),
  .vec_data_o(vec_data_o), .vec_data_oe(vec_data_oe), .irq_req(irq_req));

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb
  import viau_pkg::*;
;
  logic         aclk, aresetn, awv, wv, bready, arv, rready, two, lo_tb, hi;
  logic         awready, wready, bvalid, arready, rvalid, lo_o, lo_oe, oe, irq, stb_n, got;
  logic [7:0]   awaddr, araddr, vec, seen;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  viau_src_type ev;
  int           fail_count, compares;
  wire          lo_pin = lo_oe ? lo_o : lo_tb;
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  viau_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_event(ev),
    .irq_ack_strobe_n(stb_n), .bus_mode_two_pulse(two), .chain_enable_out_or_addr_lo_i(lo_pin),
    .chain_enable_out_or_addr_lo_o(lo_o), .chain_enable_out_or_addr_lo_oe(lo_oe),
    .chain_enable_in_or_addr_hi(hi), .vec_data_o(vec), .vec_data_oe(oe), .irq_req(irq));
  viau_host host (
    .aclk(aclk), .vec_data_o(vec), .vec_data_oe(oe), .irq_ack_strobe_n(stb_n),
    .seen(seen), .got(got));
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic give_up;
    fail_count++;
    $display("wait limit ran out at %0t", $time);
    report_and_stop();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awv <= 1'b0;
      if (wready === 1'b1) wv <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 40) give_up();
    else chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arv <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 40) give_up();
    else begin
      chk(rdata, d);
      chk(32'(rresp), 32'(er));
    end
  endtask
  task automatic pulse(input logic [23:0] e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= '0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic ack(input logic t, input logic g, input logic [7:0] v);
    host.ack_cycle(t);
    chk(32'(got), 32'(g));
    if (g) chk(32'(seen), 32'(v));
  endtask
  task automatic t_reset;
    rd(VIAU_OFF_CFG, 32'(VIAU_CFG_RESET), VIAU_RESP_OKAY);
    rd(VIAU_OFF_MSKA, 32'(VIAU_MASK_RESET), VIAU_RESP_OKAY);
    rd(VIAU_OFF_STP, 32'(VIAU_STAT_RESET), VIAU_RESP_OKAY);
    rd(8'h20, '0, VIAU_RESP_SLVERR);
    wr(8'h24, 32'h1, 4'h1, VIAU_RESP_SLVERR);
    wr(VIAU_OFF_CFG, 32'h0f, 4'h0, VIAU_RESP_OKAY);
    rd(VIAU_OFF_CFG, '0, VIAU_RESP_OKAY);
    chk(32'(irq), '0);
    $display("test reset done");
  endtask
  task automatic t_prio;
    hi <= 1'b1;
    lo_tb <= 1'b0;
    wr(VIAU_OFF_CFG, 32'h04, 4'h1, VIAU_RESP_OKAY);
    pulse(24'h010104);
    chk(32'(irq), 32'h1);
    rd(VIAU_OFF_GSUM, 32'h07, VIAU_RESP_OKAY);
    ack(1'b0, 1'b1, VIAU_VEC_TBL[2]);
    ack(1'b0, 1'b1, VIAU_VEC_TBL[3]);
    ack(1'b0, 1'b1, VIAU_VEC_TBL[6]);
    rd(VIAU_OFF_STA, '0, VIAU_RESP_OKAY);
    rd(VIAU_OFF_STP, 32'h01, VIAU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(irq), '0);
    $display("test priority done");
  endtask
  task automatic t_slave;
    hi <= 1'b0;
    lo_tb <= 1'b1;
    pulse(24'h000001);
    ack(1'b0, 1'b0, 8'h00);
    hi <= 1'b1;
    lo_tb <= 1'b0;
    two <= 1'b1;
    repeat (6) @(posedge aclk);
    ack(1'b1, 1'b1, VIAU_VEC_TBL[0]);
    two <= 1'b0;
    chk(32'(irq), '0);
    $display("test slave address done");
  endtask
  task automatic t_mask;
    wr(VIAU_OFF_MSKA, 32'h01, 4'h1, VIAU_RESP_OKAY);
    pulse(24'h000001);
    chk(32'(irq), '0);
    rd(VIAU_OFF_STA, '0, VIAU_RESP_OKAY);
    wr(VIAU_OFF_MSKA, '0, 4'h1, VIAU_RESP_OKAY);
    rd(VIAU_OFF_GSUM, 32'h01, VIAU_RESP_OKAY);
    rd(VIAU_OFF_STA, 32'h01, VIAU_RESP_OKAY);
    wr(VIAU_OFF_CFG, 32'h0c, 4'h1, VIAU_RESP_OKAY);
    wr(VIAU_OFF_MSKA, 32'h01, 4'h1, VIAU_RESP_OKAY);
    pulse(24'h000021);
    ack(1'b0, 1'b1, VIAU_VEC_TBL[6]);
    rd(VIAU_OFF_GSUM, 32'h01, VIAU_RESP_OKAY);
    rd(VIAU_OFF_STA, 32'h21, VIAU_RESP_OKAY);
    rd(VIAU_OFF_STA, '0, VIAU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(irq), '0);
    wr(VIAU_OFF_MSKA, '0, 4'h1, VIAU_RESP_OKAY);
    $display("test masking done");
  endtask
  task automatic t_daisy;
    hi <= 1'b0;
    wr(VIAU_OFF_CFG, 32'h01, 4'h1, VIAU_RESP_OKAY);
    pulse(24'h000002);
    chk(32'(irq), '0);
    chk(32'(lo_pin), '0);
    hi <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'(irq), 32'h1);
    chk(32'(lo_pin), '0);
    ack(1'b0, 1'b1, VIAU_VEC_TBL[1]);
    chk(32'(irq), '0);
    chk(32'(lo_pin), 32'h1);
    fork
      host.ack_cycle(1'b0);
      begin
        repeat (6) @(posedge aclk);
        ev <= 24'h000001;
        @(posedge aclk);
        ev <= '0;
        repeat (2) @(posedge aclk);
        chk(32'(irq), '0);
      end
    join
    chk(32'(seen), 32'(VIAU_VEC_TBL[7]));
    chk(32'(irq), 32'h1);
    ack(1'b0, 1'b1, VIAU_VEC_TBL[0]);
    chk(32'(irq), '0);
    $display("test daisy chain done");
  endtask
  initial begin
    {awv, wv, bready, arv, rready, two, lo_tb, hi} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    ev = '0;
    fail_count = 0;
    compares = 0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_prio();
    t_slave();
    t_mask();
    t_daisy();
    report_and_stop();
  end
endmodule
